/* src/seq_defines.svh */
`ifndef SEQ_DEFINES_SVH
`define SEQ_DEFINES_SVH
// item count and index layout
`define N_ITEMS 22
`define STEP_W 5
`define IDX_LDO0 0
`define IDX_PDDIS 10
`define IDX_RAIL0 11
`define IDX_BUCK0 13
`define IDX_RISE0 17
`define IDX_FALL0 19
`define IDX_WAIT 21
`define N_SUPPLY 16
`define IDX_CORE_LDO 0
// timing
`define CLK_MHZ 50
`define DOMAIN_GAP_US 32
`define DOMAIN_GAP_CYC (`DOMAIN_GAP_US * `CLK_MHZ)
`define STEP_DELAY_DEF_US 1285
`define STEP_DELAY_MIN_US 32
`define STEP_DELAY_MAX_MS 816
`define STEP_CODE_DEF 4'h6
`define WAIT_TIMEOUT_MS 500
`define WAIT_TIMEOUT_CYC (`WAIT_TIMEOUT_MS * 1000 * `CLK_MHZ)
`define CNT_W 26
`endif

/* src/seq_pkg.sv */
package seq_pkg;
  // pointer set bounding the three domains
  typedef struct packed {
    logic [4:0] base_end;
    logic [4:0] oper_end;
    logic [4:0] final_count;
    logic [4:0] partial_down_pointer;
  } seq_ptrs_t;
  // step 0 configuration and options
  typedef struct packed {
    logic default_supply_bit;
    logic otp_reload_enable;
    logic ready_enable;
    logic force_base_down;
    logic reset_assert_config;
    logic sub_done_resets;
    logic wait_timeout_enable;
    logic watchdog_enable;
  } seq_cfg_t;
  // host requests
  typedef struct packed {
    logic base_domain_enable;
    logic operating_domain_enable;
    logic sub_operating_enable;
    logic deep_low_power_bit;
    logic shutdown;
  } seq_req_t;
  // domain and status outputs
  typedef struct packed {
    logic base_up_indicator;
    logic operating_up_indicator;
    logic sub_operating_up_indicator;
    logic ready;
    logic external_wake_output;
    logic reset_output_low;
    logic active_mode;
    logic wait_failure;
  } seq_stat_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_STEP0, ST_GAP, ST_UP, ST_DOWN, ST_HOLD, ST_WAITIN, ST_WDOG, ST_SHUT
  } seq_state_t;
endpackage

/* src/seq_step_timer.sv */
`timescale 1ns/100ps
`include "seq_defines.svh"
// loadable down counter, pulses done once when count reaches one
module seq_step_timer (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic load,
  input wire logic [`CNT_W-1:0] count,
  output logic done
);
  logic [`CNT_W-1:0] cnt_r;
  logic run_r;
  // load wins over the running count
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      run_r <= 1'b0;
      done <= 1'b0;
    end else if (load) begin
      cnt_r <= count;
      run_r <= 1'b1;
      done <= 1'b0;
    end else begin
      done <= run_r && (cnt_r <= `CNT_W'h1);
      if (run_r && cnt_r > `CNT_W'h1) begin
        cnt_r <= cnt_r - `CNT_W'h1;
      end else begin
        run_r <= 1'b0;
      end
    end
  end
endmodule

/* src/power_domain_sequencer.sv */
`timescale 1ns/100ps
`include "seq_defines.svh"
module power_domain_sequencer (
  input wire logic clk_sys,
  input wire logic rst,
  input wire seq_pkg::seq_ptrs_t ptrs,
  input wire seq_pkg::seq_cfg_t cfg,
  input wire seq_pkg::seq_req_t req_pin,
  input wire logic [`N_ITEMS*`STEP_W-1:0] slot_map,
  input wire logic [`N_SUPPLY-1:0] preset_mask,
  input wire logic [`N_SUPPLY-1:0] otp_default_en,
  input wire logic [3:0] step_delay_field,
  input wire logic [3:0] dummy_step_delay,
  input wire logic wait_input_ten,
  input wire logic host_alive,
  input wire logic [15:0] reset_timer_cycles,
  output seq_pkg::seq_stat_t stat,
  output logic [`N_SUPPLY-1:0] supply_en,
  output logic [`N_SUPPLY-1:0] supply_preset,
  output logic powerdown_feature_disable,
  output logic feedback_pin_two,
  output logic sequence_done_irq,
  output logic otp_reload,
  output logic [`STEP_W-1:0] step_count
);
  import seq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, first stage only feeds the second
  logic [5:0] sync1_r, sync2_r;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {req_pin, wait_input_ten};
      sync2_r <= sync1_r;
    end
  end
  seq_req_t req;
  logic wait_in;
  assign req = sync2_r[5:1];
  assign wait_in = sync2_r[0];

  ////////////////////////////////////////////////////////////////////////////
  // delay code to cycles: 32 us doubling, code 6 fixed at 1285 us, clamped to the maximum
  function automatic logic [`CNT_W-1:0] code_cycles(input logic [3:0] code);
    logic [31:0] us;
    us = 32'(`STEP_DELAY_MIN_US) << code;
    if (code == `STEP_CODE_DEF) us = 32'(`STEP_DELAY_DEF_US);
    if (us > 32'(`STEP_DELAY_MAX_MS * 1000)) us = 32'(`STEP_DELAY_MAX_MS * 1000);
    code_cycles = `CNT_W'(us * 32'(`CLK_MHZ));
  endfunction

  seq_state_t state_r;
  logic [`STEP_W-1:0] step_r, target_r;
  logic dir_up_r;
  logic [3:0] step_code_r, dummy_code_r;
  logic timer_load;
  logic [`CNT_W-1:0] timer_count;
  logic timer_done;
  logic [`CNT_W-1:0] wait_cnt_r;
  logic [15:0] rst_cnt_r;
  logic rst_timer_run_r;
  logic gap_after_r;

  seq_step_timer u_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(timer_load),
    .count(timer_count),
    .done(timer_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // slot compare: which items act in the current step
  logic [`N_ITEMS-1:0] hit; // one compare per item
  logic any_hit;
  always_comb begin
    for (int i = 0; i < `N_ITEMS; i++) begin
      // zero slot or at/after final count is never sequenced
      hit[i] = (slot_map[i*`STEP_W +: `STEP_W] == step_r) && (step_r != '0) &&
               (slot_map[i*`STEP_W +: `STEP_W] < ptrs.final_count);
    end
    any_hit = |hit;
  end

  // domain borders, not read by the gap or indicator logic
  logic at_border;
  assign at_border = (step_r == ptrs.base_end) || (step_r == ptrs.oper_end) ||
                     (step_r == '0);

  // preset presence per domain
  logic [2:0] dom_preset;
  always_comb begin
    dom_preset = '0;
    for (int i = 0; i < `N_SUPPLY; i++) begin
      logic [`STEP_W-1:0] s;
      s = slot_map[(i < 10 ? i : i + 1)*`STEP_W +: `STEP_W];
      if (preset_mask[i] && s != '0) begin
        if (s <= ptrs.base_end) dom_preset[0] = 1'b1;
        else if (s <= ptrs.oper_end) dom_preset[1] = 1'b1;
        else dom_preset[2] = 1'b1;
      end
    end
  end

  // delay for the next step: empty slot uses dummy delay
  always_comb begin
    // load lands one cycle after the state change, so state_r already names the wait
    if (state_r == ST_GAP) timer_count = `CNT_W'(`DOMAIN_GAP_CYC);
    else timer_count = any_hit ? code_cycles(step_code_r) : code_cycles(dummy_code_r);
  end

  ////////////////////////////////////////////////////////////////////////////
  // main state machine
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      step_r <= '0;
      target_r <= '0;
      dir_up_r <= 1'b1;
      timer_load <= 1'b0;
      gap_after_r <= 1'b0;
      wait_cnt_r <= '0;
    end else begin
      timer_load <= 1'b0;
      unique case (state_r)
        ST_IDLE: begin
          if (req.base_domain_enable) begin
            state_r <= ST_STEP0;
            dir_up_r <= 1'b1;
          end
        end
        ST_STEP0: begin
          // one cycle of step 0 configuration, then domain entry gap
          target_r <= ptrs.base_end;
          state_r <= ST_GAP;
          timer_load <= 1'b1;
          gap_after_r <= 1'b0;
        end
        ST_GAP: begin
          if (timer_done) begin
            if (gap_after_r) begin
              // operating domain up: enter ST_WDOG, which takes requests as ST_HOLD does; host alive sets active mode and clears the external wake output
              state_r <= (dir_up_r && step_r == ptrs.oper_end) ? ST_WDOG : ST_HOLD;
            end else begin
              state_r <= dir_up_r ? ST_UP : ST_DOWN;
              if (dir_up_r) step_r <= step_r + `STEP_W'h1;
              timer_load <= 1'b1;
            end
          end
        end
        ST_UP: begin
          if (timer_done) begin
            if (hit[`IDX_WAIT] && !wait_in) begin
              state_r <= ST_WAITIN;
              wait_cnt_r <= '0;
            end else if (step_r == target_r) begin
              state_r <= ST_GAP;
              gap_after_r <= 1'b1;
              timer_load <= 1'b1;
            end else begin
              step_r <= step_r + `STEP_W'h1;
              timer_load <= 1'b1;
            end
          end
        end
        ST_WAITIN: begin
          wait_cnt_r <= wait_cnt_r + `CNT_W'h1;
          if (wait_in) begin
            state_r <= ST_UP;
            timer_load <= 1'b1;
          end else if (cfg.wait_timeout_enable &&
                       wait_cnt_r >= `CNT_W'(`WAIT_TIMEOUT_CYC - 1)) begin
            state_r <= ST_SHUT;
            target_r <= '0;
            dir_up_r <= 1'b0;
          end
        end
        ST_DOWN: begin
          if (timer_done) begin
            // the target step belongs to the domain that stays up
            step_r <= step_r - `STEP_W'h1;
            timer_load <= 1'b1;
            if (step_r - `STEP_W'h1 == target_r) begin
              state_r <= ST_GAP;
              gap_after_r <= 1'b1;
            end
          end
        end
        ST_SHUT: begin
          state_r <= ST_GAP;
          gap_after_r <= 1'b0;
          timer_load <= 1'b1;
        end
        ST_WDOG, ST_HOLD: begin
          // choose next transition from the held requests
          dir_up_r <= 1'b1;
          if (req.shutdown || !req.base_domain_enable) begin
            if (step_r != '0) begin
              target_r <= '0;
              dir_up_r <= 1'b0;
              state_r <= ST_SHUT;
            end else begin
              state_r <= ST_IDLE;
            end
          end else if (req.deep_low_power_bit && step_r > ptrs.partial_down_pointer) begin
            target_r <= ptrs.partial_down_pointer;
            dir_up_r <= 1'b0;
            state_r <= ST_SHUT;
          end else if (!req.operating_domain_enable && step_r > ptrs.base_end) begin
            target_r <= ptrs.base_end;
            dir_up_r <= 1'b0;
            state_r <= ST_SHUT;
          end else if (!req.sub_operating_enable && step_r > ptrs.oper_end) begin
            target_r <= ptrs.oper_end;
            dir_up_r <= 1'b0;
            state_r <= ST_SHUT;
          end else if (!req.deep_low_power_bit && step_r < ptrs.base_end) begin
            target_r <= ptrs.base_end;
            state_r <= ST_GAP;
            gap_after_r <= 1'b0;
            timer_load <= 1'b1;
          end else if (req.operating_domain_enable && step_r == ptrs.base_end) begin
            target_r <= ptrs.oper_end;
            state_r <= ST_GAP;
            gap_after_r <= 1'b0;
            timer_load <= 1'b1;
          end else if (req.sub_operating_enable && req.operating_domain_enable &&
                       step_r == ptrs.oper_end) begin
            target_r <= ptrs.final_count;
            state_r <= ST_GAP;
            gap_after_r <= 1'b0;
            timer_load <= 1'b1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // supply switching; all same-slot items act together
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      supply_en <= '0;
      supply_preset <= '0;
      powerdown_feature_disable <= 1'b0;
      feedback_pin_two <= 1'b0;
    end else if (state_r == ST_STEP0 && cfg.default_supply_bit) begin
      for (int i = 0; i < `N_SUPPLY; i++) begin
        if (i != `IDX_CORE_LDO) supply_en[i] <= otp_default_en[i];
      end
    end else if ((state_r == ST_UP || state_r == ST_DOWN) && timer_done) begin
      for (int i = 0; i < `N_SUPPLY; i++) begin
        if (hit[i < 10 ? i : i + 1]) begin
          if (state_r == ST_UP) begin
            supply_en[i] <= 1'b1;
            supply_preset[i] <= 1'b0;
          end else if (preset_mask[i]) begin
            supply_preset[i] <= 1'b1;
          end else begin
            supply_en[i] <= 1'b0;
          end
        end
      end
      if (hit[`IDX_PDDIS]) powerdown_feature_disable <= (state_r == ST_DOWN);
      if (hit[`IDX_RISE0] || hit[`IDX_RISE0+1]) feedback_pin_two <= (state_r == ST_UP);
      if (hit[`IDX_FALL0] || hit[`IDX_FALL0+1]) feedback_pin_two <= (state_r == ST_DOWN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // delay codes reloaded in step 0, before each base power-up from idle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      step_code_r <= `STEP_CODE_DEF;
      dummy_code_r <= `STEP_CODE_DEF;
      otp_reload <= 1'b0;
    end else begin
      otp_reload <= (state_r == ST_STEP0) && cfg.otp_reload_enable;
      if (state_r == ST_STEP0) begin
        step_code_r <= step_delay_field;
        dummy_code_r <= dummy_step_delay;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indicators, ready, irq, wake, reset output
  logic done_evt;
  assign done_evt = (state_r == ST_GAP) && timer_done && gap_after_r;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stat <= '0;
      sequence_done_irq <= 1'b0;
      rst_cnt_r <= '0;
      rst_timer_run_r <= 1'b0;
    end else begin
      sequence_done_irq <= done_evt;
      stat.ready <= cfg.ready_enable && (state_r == ST_UP || state_r == ST_DOWN ||
                    state_r == ST_GAP && !gap_after_r);
      if (done_evt && dir_up_r) begin
        if (step_r == ptrs.base_end) stat.base_up_indicator <= 1'b1;
        if (step_r == ptrs.oper_end) stat.operating_up_indicator <= 1'b1;
        if (step_r == ptrs.final_count) begin
          stat.sub_operating_up_indicator <= 1'b1;
          if (cfg.sub_done_resets) rst_timer_run_r <= 1'b1;
        end
        if (step_r == ptrs.base_end && !cfg.sub_done_resets) rst_timer_run_r <= 1'b1;
      end
      // drop indicator before first supply of a domain without preset supply goes down; force_base_down drops base anyway
      if (state_r == ST_DOWN) begin
        if (step_r > ptrs.oper_end && !dom_preset[2]) stat.sub_operating_up_indicator <= 1'b0;
        if (step_r > ptrs.base_end && step_r <= ptrs.oper_end && !dom_preset[1])
          stat.operating_up_indicator <= 1'b0;
        if (step_r <= ptrs.base_end && (!dom_preset[0] || cfg.force_base_down))
          stat.base_up_indicator <= 1'b0;
      end
      if (state_r == ST_WDOG && host_alive) begin
        stat.active_mode <= 1'b1;
        stat.external_wake_output <= 1'b0;
      end
      if (state_r == ST_STEP0) stat.external_wake_output <= 1'b1;
      if (state_r == ST_WAITIN && cfg.wait_timeout_enable &&
          wait_cnt_r >= `CNT_W'(`WAIT_TIMEOUT_CYC - 1)) stat.wait_failure <= 1'b1;
      if (state_r == ST_SHUT) stat.active_mode <= 1'b0;
      // reset output asserted at end of power-down, timed release on power-up
      if (done_evt && !dir_up_r && cfg.reset_assert_config) begin
        stat.reset_output_low <= 1'b1;
        rst_timer_run_r <= 1'b0;
      end
      if (rst_timer_run_r) begin
        rst_cnt_r <= rst_cnt_r + 16'h1;
        if (rst_cnt_r >= reset_timer_cycles) begin
          stat.reset_output_low <= 1'b0;
          rst_timer_run_r <= 1'b0;
          rst_cnt_r <= '0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) step_count <= '0;
    else step_count <= step_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_irq_after_done;
    @(posedge clk_sys) disable iff (rst) done_evt |=> sequence_done_irq;
  endproperty
  a_irq_after_done: assert property (p_irq_after_done) else $error("irq missing");
  property p_step_bound;
    @(posedge clk_sys) disable iff (rst) state_r == ST_UP |-> step_r <= target_r;
  endproperty
  a_step_bound: assert property (p_step_bound) else $error("step past target");
  property p_down_not_up;
    @(posedge clk_sys) disable iff (rst) state_r == ST_DOWN |-> !dir_up_r;
  endproperty
  a_down_not_up: assert property (p_down_not_up) else $error("direction wrong");
  property p_core_kept;
    @(posedge clk_sys) disable iff (rst)
      state_r == ST_STEP0 |=> supply_en[0] == $past(supply_en[0]);
  endproperty
  a_core_kept: assert property (p_core_kept) else $error("core ldo changed");
  property p_step_one;
    @(posedge clk_sys) disable iff (rst)
      $rose(state_r == ST_UP) && $past(step_r) == '0 |-> step_r == `STEP_W'h1;
  endproperty
  a_step_one: assert property (p_step_one) else $error("base not at step 1");
  property p_reload;
    @(posedge clk_sys) disable iff (rst)
      state_r == ST_STEP0 && cfg.otp_reload_enable |=> otp_reload;
  endproperty
  a_reload: assert property (p_reload) else $error("no reload");
  property p_codes;
    @(posedge clk_sys) disable iff (rst)
      state_r == ST_STEP0 |=> step_code_r == $past(step_delay_field);
  endproperty
  a_codes: assert property (p_codes) else $error("step code not loaded");
  property p_wait_hold;
    @(posedge clk_sys) disable iff (rst)
      state_r == ST_WAITIN && !wait_in && !cfg.wait_timeout_enable |=> state_r == ST_WAITIN;
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("wait left early");
endmodule

/* testbench/host_model.sv */
`timescale 1ns/100ps
// host processor side: domain enable lines and alive feedback
module host_model (
  input wire logic clk_sys,
  input wire logic sequence_done_irq,
  input wire seq_pkg::seq_stat_t stat,
  output seq_pkg::seq_req_t req_pin,
  output logic host_alive
);
  import seq_pkg::*;
  initial begin
    req_pin = '0;
    host_alive = 1'b0;
  end
  // alive feedback once the operating domain reports up
  always @(posedge clk_sys) begin
    host_alive <= #1 stat.operating_up_indicator;
  end
  // one request, then hold off until the done pulse; bounded wait
  task automatic request(input seq_req_t r, output logic done, output logic saw_ready);
    int n;
    @(posedge clk_sys);
    #1 req_pin = r;
    done = 1'b0;
    saw_ready = 1'b0;
    for (n = 0; n < 20000 && !done; n++) begin
      @(posedge clk_sys);
      if (stat.ready === 1'b1) saw_ready = 1'b1;
      if (sequence_done_irq === 1'b1) done = 1'b1;
    end
  endtask
endmodule

/* testbench/testbench.sv */
`timescale 1ns/100ps
`include "seq_defines.svh"
module testbench;
  import seq_pkg::*;
  logic clk_sys;
  logic rst;
  seq_ptrs_t ptrs;
  seq_cfg_t cfg;
  seq_req_t req_pin;
  seq_req_t r;
  logic [`N_ITEMS*`STEP_W-1:0] slot_map;
  logic [`N_SUPPLY-1:0] preset_mask;
  logic [`N_SUPPLY-1:0] otp_default_en;
  logic wait_input_ten;
  logic host_alive;
  seq_stat_t stat;
  logic [`N_SUPPLY-1:0] supply_en;
  logic [`N_SUPPLY-1:0] supply_preset;
  logic powerdown_feature_disable;
  logic sequence_done_irq;
  logic done;
  logic rdy;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;

  power_domain_sequencer dut (
    .clk_sys(clk_sys), .rst(rst), .ptrs(ptrs), .cfg(cfg), .req_pin(req_pin),
    .slot_map(slot_map), .preset_mask(preset_mask), .otp_default_en(otp_default_en),
    .step_delay_field(4'h0), .dummy_step_delay(4'h0), .wait_input_ten(wait_input_ten),
    .host_alive(host_alive), .reset_timer_cycles(16'h0010), .stat(stat),
    .supply_en(supply_en), .supply_preset(supply_preset),
    .powerdown_feature_disable(powerdown_feature_disable), .feedback_pin_two(),
    .sequence_done_irq(sequence_done_irq), .otp_reload(), .step_count()
  );
  host_model host (
    .clk_sys(clk_sys), .sequence_done_irq(sequence_done_irq), .stat(stat),
    .req_pin(req_pin), .host_alive(host_alive)
  );

  ////////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // hang guard, well above the roughly 40k cycles the sequences need
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 90000) begin
      errors++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic put_slot(input int item, input int slot);
    slot_map[item*`STEP_W +: `STEP_W] = slot[`STEP_W-1:0];
  endtask
  task automatic wrap_up();
    if (errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    // pointers strictly ascending, operating above base by two slots
    ptrs = '{base_end: 5'h02, oper_end: 5'h04, final_count: 5'h07,
             partial_down_pointer: 5'h01};
    cfg = '0;
    cfg.default_supply_bit = 1'b1;
    cfg.ready_enable = 1'b1;
    slot_map = '0;
    put_slot(1, 1); // two ldos share slot 1
    put_slot(2, 1);
    put_slot(10, 2); // feature disable
    put_slot(13, 2); // buck 0, preset supply
    put_slot(14, 4); // slot 3 left empty as delay step
    put_slot(15, 5);
    put_slot(16, 7); // at final count: never switched
    preset_mask = 16'h1000;
    otp_default_en = 16'h0009; // core ldo and ldo 3
    wait_input_ten = 1'b1;
    repeat (20) @(posedge clk_sys);
    #1 rst = 1'b0;
    chk(stat, 8'h00);
    chk(supply_en, 16'h0000);
    repeat (3) @(posedge clk_sys);
    // base domain up
    r = '0;
    r.base_domain_enable = 1'b1;
    host.request(r, done, rdy);
    chk(done, 1'b1);
    chk(rdy, 1'b1);
    chk(stat.base_up_indicator, 1'b1);
    chk(stat.ready, 1'b0);
    chk(supply_en, 16'h1008 | 16'h0006);
    chk(powerdown_feature_disable, 1'b0);
    chk(supply_en[0], 1'b0);
    // operating domain up, passing the empty slot
    r.operating_domain_enable = 1'b1;
    host.request(r, done, rdy);
    chk(done, 1'b1);
    chk(rdy, 1'b1);
    chk(stat.operating_up_indicator, 1'b1);
    chk(supply_en[13], 1'b1);
    repeat (4) @(posedge clk_sys);
    chk(stat.active_mode, 1'b1);
    chk(stat.external_wake_output, 1'b0);
    // sub-operating domain up
    r.sub_operating_enable = 1'b1;
    host.request(r, done, rdy);
    chk(done, 1'b1);
    chk(stat.sub_operating_up_indicator, 1'b1);
    chk(supply_en[15:14], 2'b01);
    chk(supply_en[5], 1'b0);
    // release sub-operating: stop at operating end
    r.sub_operating_enable = 1'b0;
    host.request(r, done, rdy);
    chk(done, 1'b1);
    chk(rdy, 1'b1);
    chk(stat.sub_operating_up_indicator, 1'b0);
    chk(supply_en[14:13], 2'b01);
    // release operating: stop at base end
    r.operating_domain_enable = 1'b0;
    host.request(r, done, rdy);
    chk(done, 1'b1);
    chk(stat.operating_up_indicator, 1'b0);
    chk(stat.base_up_indicator, 1'b1);
    chk(supply_en[13], 1'b0);
    chk(supply_en[2:1], 2'b11);
    // release base: down to step 0, preset supply kept
    r.base_domain_enable = 1'b0;
    host.request(r, done, rdy);
    chk(done, 1'b1);
    chk(supply_en[2:1], 2'b00);
    chk(supply_en[12], 1'b1);
    chk(supply_preset[12], 1'b1);
    chk(stat.base_up_indicator, 1'b1);
    chk(powerdown_feature_disable, 1'b1);
    wrap_up();
  end
endmodule
